//--- core/mvd_pkg.sv
// Constants, layouts and types for the memory decoder and vector logic.
// Assumes one clock domain; the CPU core and APB master share pclk.
// How it works
// - The decoder covers a 32 Kbyte space of memories and I/O registers.
// - RAM holds up to 1024 bytes, of which the low 64 bytes are the register page.
// - The stack uses at most 128 bytes of RAM, from 0100h through 017Fh.
// - The top 32 bytes of program memory hold vectors, not user code.
// - External lines one to eight share vector FFF6h, are maskable and wake from Halt.
// - Serial bus end-of-suspend vectors at FFF8h, is maskable and wakes from Halt.
// - Flash-programming-start vectors at FFFAh, is maskable and wakes from Halt.
// - The software trap vectors at FFFCh, is never masked and does not wake from Halt.
// - Reset vectors at FFFEh, is never masked and always wakes from Halt.
// - Port A value and direction registers sit at index 0 and 1, read/write, reset 00h.
// - Port B value and direction registers sit at index 2 and 3, read/write, reset 00h.
package mvd_pkg;
    localparam int CPU_AW = 16;
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;
    localparam int REG_W = 8;
    localparam int IDX_W = 10;
    localparam int EXT_LINES = 8;
    // Space and regions
    localparam int SPACE_BYTES = 32768;
    localparam int RAM_BYTES = 1024;
    localparam int PROG_BYTES = 32768;
    localparam logic [15:0] REG_PAGE_LAST = 16'h003F;
    localparam logic [15:0] STACK_FIRST = 16'h0100;
    localparam logic [15:0] STACK_LAST = 16'h017F;
    localparam logic [15:0] VEC_FIRST = 16'hFFE0;
    localparam logic [15:0] VEC_RSVD_LAST = 16'hFFED;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_PA_OUT = 10'h000;
    localparam logic [9:0] IDX_PA_DIR = 10'h001;
    localparam logic [9:0] IDX_PB_OUT = 10'h002;
    localparam logic [9:0] IDX_PB_DIR = 10'h003;
    localparam logic [9:0] IDX_STATUS = 10'h004;
    localparam logic [9:0] IDX_CLEAR = 10'h005;
    localparam logic [9:0] IDX_ENABLE = 10'h006;
    localparam logic [9:0] IDX_RSVD_ADDR = 10'h007;
    localparam logic [7:0] PORT_RESET = 8'h00;
    // Status bits
    localparam int SRC_USB = 0;
    localparam int SRC_SCI = 1;
    localparam int SRC_I2C = 2;
    localparam int SRC_TIMER = 3;
    localparam int SRC_EXT = 4;
    localparam int SRC_SUSP = 5;
    localparam int SRC_FLASH = 6;
    localparam int SRC_RSVD = 7;
    localparam int N_VEC_SRC = 7;
    localparam int N_STAT = 8;
    localparam int LINE_LSB = 8;
    localparam logic [6:0] WAKE_CAPABLE = 7'h70;
    // Selector slots above the maskable ones
    localparam int SEL_TRAP = 7;
    localparam int SEL_RESET = 8;
    localparam int N_SEL = 9;
    localparam logic [3:0] SLOT_BASE = 4'h7;
    typedef struct packed {
        logic ram;
        logic reg_page;
        logic stack;
        logic prog;
        logic vector;
        logic reserved;
    } mvd_region_t;
    typedef struct packed {
        logic req;
        logic [3:0] slot;
        logic [15:0] addr;
    } mvd_vec_t;
endpackage : mvd_pkg

//--- core/mvd_prio_sel.sv
// Priority picker: highest set request bit wins.
// Assumes pending bits are stable within the cycle.
`timescale 1ns/10ps
module mvd_prio_sel #(
    parameter int N = 9
) (
    input wire logic [N-1:0] pending,
    output logic valid,
    output logic [3:0] index
);
    always_comb begin
        valid = 1'b0;
        index = 4'h0;
        // Later entries overwrite earlier, so the top bit wins
        for (int i = 0; i < N; i++) begin
            if (pending[i]) begin
                valid = 1'b1;
                index = 4'(i);
            end
        end
    end
endmodule : mvd_prio_sel

//--- core/mvd_top.sv
// Address decoder, vector table and port registers of the controller.
// Assumes CPU core and APB master run on pclk; events are one-cycle pulses.
// Reserved accesses are flagged and captured, never blocked.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
module mvd_top #(
    parameter int RAM_BYTES = mvd_pkg::RAM_BYTES,
    parameter int PROG_BYTES = mvd_pkg::PROG_BYTES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_mem_valid,
    output mvd_pkg::mvd_region_t cpu_region,
    input wire logic [7:0] external_interrupt_lines,
    input wire logic usb_irq,
    input wire logic async_serial_interface_irq,
    input wire logic two_wire_irq,
    input wire logic timer_irq,
    input wire logic usb_end_suspend,
    input wire logic flash_prog_start,
    input wire logic cpu_trap,
    input wire logic cpu_i_bit,
    input wire logic cpu_halted,
    input wire logic cpu_int_ack,
    output logic cpu_int_req,
    output logic [15:0] cpu_vector,
    output logic wake_from_halt,
    output logic irq,
    output logic [7:0] port_a_output_value,
    output logic [7:0] port_a_direction,
    output logic [7:0] port_b_output_value,
    output logic [7:0] port_b_direction
);
    localparam logic [16:0] RAM_END = 17'(RAM_BYTES);
    // Program memory ends at the top of the 16-bit CPU space
    localparam logic [16:0] PROG_FIRST = 17'((1 << mvd_pkg::CPU_AW) - PROG_BYTES);
    localparam logic [16:0] SPACE_END = 17'(mvd_pkg::SPACE_BYTES);

    // Address decode
    wire [16:0] addr_x = {1'b0, cpu_addr};
    wire in_ram;
    wire in_regs;
    wire in_stack;
    wire in_vec;
    wire in_vec_rsvd;
    wire in_prog;
    wire in_space;

    // Register page overlaps RAM; it takes precedence in the region bits
    // RAM with register page
    assign in_ram = addr_x < RAM_END;
    assign in_regs = cpu_addr <= mvd_pkg::REG_PAGE_LAST;

    // Stack only counts inside RAM, so a smaller RAM shrinks it
    // stack window
    assign in_stack = (cpu_addr >= mvd_pkg::STACK_FIRST)
        && (cpu_addr <= mvd_pkg::STACK_LAST) && in_ram;

    // Program decode stops below the table so user code never lands there
    // vector area kept apart
    assign in_vec = cpu_addr >= mvd_pkg::VEC_FIRST;
    assign in_prog = (addr_x >= PROG_FIRST) && !in_vec;
    assign in_vec_rsvd = in_vec && (cpu_addr <= mvd_pkg::VEC_RSVD_LAST);

    // bounded space
    // Only the program area must fit the decoded space; RAM sits in the
    // low page below it and the gap between them decodes as reserved
    wire space_fits = 17'(PROG_BYTES) <= SPACE_END;
    assign in_space = (in_ram || in_prog || in_vec) && space_fits;

    // Flagged only: the core still runs the cycle, software must avoid it
    // reserved holes flagged
    assign cpu_region.ram = in_ram && !in_regs;
    assign cpu_region.reg_page = in_regs;
    assign cpu_region.stack = in_stack;
    assign cpu_region.prog = in_prog;
    assign cpu_region.vector = in_vec && !in_vec_rsvd;
    assign cpu_region.reserved = in_vec_rsvd || !in_space;

    wire rsvd_event = cpu_mem_valid && cpu_region.reserved;

    // APB decode
    wire [9:0] idx = paddr[11:2];
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire hit_pa_out = idx == mvd_pkg::IDX_PA_OUT;
    wire hit_pa_dir = idx == mvd_pkg::IDX_PA_DIR;
    wire hit_pb_out = idx == mvd_pkg::IDX_PB_OUT;
    wire hit_pb_dir = idx == mvd_pkg::IDX_PB_DIR;
    wire hit_status = idx == mvd_pkg::IDX_STATUS;
    wire hit_clear = idx == mvd_pkg::IDX_CLEAR;
    wire hit_enable = idx == mvd_pkg::IDX_ENABLE;
    wire hit_raddr = idx == mvd_pkg::IDX_RSVD_ADDR;
    wire hit_any = hit_pa_out || hit_pa_dir || hit_pb_out
        || hit_pb_dir || hit_status || hit_clear
        || hit_enable || hit_raddr;
    wire bad_lane = paddr[1:0] != 2'h0;
    wire ok = hit_any && !bad_lane;

    // Write strobes, one per writable register
    wire wr_ok = wr && ok;
    wire wr_pa_out = wr_ok && hit_pa_out;
    wire wr_pa_dir = wr_ok && hit_pa_dir;
    wire wr_pb_out = wr_ok && hit_pb_out;
    wire wr_pb_dir = wr_ok && hit_pb_dir;
    wire wr_clear = wr_ok && hit_clear;
    wire wr_enable = wr_ok && hit_enable;
    // Read data is fetched in the setup cycle, off the access path
    wire rd_setup = psel && !penable && !pwrite;

    // Zero wait states: every access phase completes at once
    assign pready = 1'b1;
    // Error only in access, for an unmapped index or unaligned lane
    assign pslverr = acc && !ok;

    // Interrupt state
    logic [7:0] status;
    logic [7:0] enable;
    // Per-line record behind the shared external flag
    logic [7:0] line_seen;
    logic [15:0] rsvd_addr;
    logic trap_pend;
    logic reset_pend;
    mvd_pkg::mvd_vec_t vec;

    wire [7:0] clr_bits = wr_clear ? pwdata[7:0] : 8'h00;
    wire [7:0] clr_lines = wr_clear ? pwdata[15:8] : 8'h00;

    logic [7:0] events;
    always_comb begin
        events = 8'h00;
        events[mvd_pkg::SRC_USB] = usb_irq;
        events[mvd_pkg::SRC_SCI] = async_serial_interface_irq;
        events[mvd_pkg::SRC_I2C] = two_wire_irq;
        events[mvd_pkg::SRC_TIMER] = timer_irq;
        events[mvd_pkg::SRC_EXT] = |external_interrupt_lines;
        events[mvd_pkg::SRC_SUSP] = usb_end_suspend;
        events[mvd_pkg::SRC_FLASH] = flash_prog_start;
        // Software-visible only; never offered as a vector
        events[mvd_pkg::SRC_RSVD] = rsvd_event;
    end

    // Acknowledge retires the slot currently offered
    wire ack_take = cpu_int_ack && vec.req;
    wire [3:0] ack_sel = vec.slot - mvd_pkg::SLOT_BASE;
    // One compare per slot; a stale slot code after reset indexes nothing
    wire [mvd_pkg::N_SEL-1:0] ack_mask;
    for (genvar s = 0; s < mvd_pkg::N_SEL; s++) begin : g_ack
        assign ack_mask[s] = ack_take && (ack_sel == 4'(s));
    end

    // Set wins over clear, so no event is lost
    wire [7:0] ack_src = {1'b0, ack_mask[6:0]};
    wire [7:0] next_status;
    wire [7:0] next_lines;
    for (genvar b = 0; b < mvd_pkg::N_STAT; b++) begin : g_flag
        assign next_status[b] = events[b] || (status[b] && !clr_bits[b] && !ack_src[b]);
        assign next_lines[b] = external_interrupt_lines[b] || (line_seen[b] && !clr_lines[b]);
    end

    // A new trap in the cycle of its own ack stays pending
    // trap held until taken
    wire next_trap = cpu_trap || (trap_pend && !ack_mask[mvd_pkg::SEL_TRAP]);

    // Set by reset itself and cleared only by its acknowledge
    // reset vector first
    wire next_reset = reset_pend && !ack_mask[mvd_pkg::SEL_RESET];

    // Maskable sources gated by the CPU mask bit
    // Slot order is priority order: reset, trap, then sources 6 down to 0
    wire [6:0] live_src = next_status[6:0] & enable[6:0];
    wire [6:0] unmasked = cpu_i_bit ? 7'h00 : live_src;
    wire [8:0] pending = {next_reset, next_trap, unmasked};

    wire sel_valid;
    wire [3:0] sel_index;
    mvd_prio_sel #(
        .N(mvd_pkg::N_SEL)
    ) u_sel (
        .pending(pending),
        .valid(sel_valid),
        .index(sel_index)
    );

    wire [3:0] next_slot = sel_index + mvd_pkg::SLOT_BASE;
    wire [15:0] next_vec = mvd_pkg::VEC_FIRST + {11'h000, next_slot, 1'b0};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= 8'h00;
            line_seen <= 8'h00;
            trap_pend <= 1'b0;
            reset_pend <= 1'b1;
        end else begin
            status <= next_status;
            line_seen <= next_lines;
            trap_pend <= next_trap;
            reset_pend <= next_reset;
        end
    end

    // Offer is registered, so request and vector change together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vec <= '0;
        end else begin
            vec.req <= sel_valid;
            vec.slot <= next_slot;
            vec.addr <= next_vec;
        end
    end

    assign cpu_int_req = vec.req;
    assign cpu_vector = vec.addr;

    // Wake logic ignores the mask bit; trap never wakes
    wire [6:0] wake_src = status[6:0] & enable[6:0] & mvd_pkg::WAKE_CAPABLE;
    wire wake_any = (|wake_src) || reset_pend;
    logic wake_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= cpu_halted && wake_any;
        end
    end
    assign wake_from_halt = wake_q;

    // Level output from enabled sticky bits
    // Registered so a clear in flight cannot glitch the line
    wire irq_any = |(next_status & enable);
    logic irq_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_any;
        end
    end
    assign irq = irq_q;

    // Enable and captured reserved address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable <= 8'h00;
        end else if (wr_enable) begin
            enable <= pwdata[7:0];
        end
    end

    // Latest offending address wins; earlier ones are lost until read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsvd_addr <= 16'h0000;
        end else if (rsvd_event) begin
            rsvd_addr <= cpu_addr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_output_value <= mvd_pkg::PORT_RESET;
            port_a_direction <= mvd_pkg::PORT_RESET;
        end else begin
            if (wr_pa_out) begin
                port_a_output_value <= pwdata[7:0];
            end
            if (wr_pa_dir) begin
                port_a_direction <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_output_value <= mvd_pkg::PORT_RESET;
            port_b_direction <= mvd_pkg::PORT_RESET;
        end else begin
            if (wr_pb_out) begin
                port_b_output_value <= pwdata[7:0];
            end
            if (wr_pb_dir) begin
                port_b_direction <= pwdata[7:0];
            end
        end
    end

    // Read mux; clear register reads as zero
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_pa_out) begin
            rd_word[7:0] = port_a_output_value;
        end
        if (hit_pa_dir) begin
            rd_word[7:0] = port_a_direction;
        end
        if (hit_pb_out) begin
            rd_word[7:0] = port_b_output_value;
        end
        if (hit_pb_dir) begin
            rd_word[7:0] = port_b_direction;
        end
        if (hit_status) begin
            rd_word[15:0] = {line_seen, status};
        end
        if (hit_enable) begin
            rd_word[7:0] = enable;
        end
        if (hit_raddr) begin
            rd_word[15:0] = rsvd_addr;
        end
        if (bad_lane) begin
            rd_word = 32'h0000_0000;
        end
    end

    // Read data registered in the setup cycle, stable in access
    // Trade-off: a flag set during the access phase shows on the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rd_word;
        end
    end
endmodule : mvd_top

//--- tb/mvd_cpu_model.sv
// CPU core model: takes offered vectors after a set delay.
// Assumes the bench sets the delay and watches taken.
`timescale 1ns/10ps
module mvd_cpu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cpu_int_req,
    input wire logic [15:0] cpu_vector,
    input wire logic [3:0] ack_dly,
    output logic cpu_int_ack,
    output logic taken,
    output logic [15:0] taken_vector
);
    logic [3:0] wait_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_int_ack <= 1'b0;
            taken <= 1'b0;
            taken_vector <= 16'h0000;
            wait_cnt <= 4'h0;
        end else begin
            cpu_int_ack <= 1'b0;
            taken <= 1'b0;
            wait_cnt <= 4'h0;
            if (cpu_int_req && !cpu_int_ack) begin
                wait_cnt <= wait_cnt + 4'h1;
                if (wait_cnt >= ack_dly) begin
                    cpu_int_ack <= 1'b1;
                    taken <= 1'b1;
                    taken_vector <= cpu_vector;
                end
            end
        end
    end
endmodule : mvd_cpu_model

//--- tb/mvd_top_props.sv
// Port checker for the decoder and vector logic.
// Assumes binding into mvd_top; sees its ports only.
`timescale 1ns/10ps
module mvd_top_props #(
    parameter int RAM_BYTES = 1024,
    parameter int PROG_BYTES = 32768
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    input wire logic [15:0] cpu_addr,
    input wire mvd_pkg::mvd_region_t cpu_region,
    input wire logic cpu_trap,
    input wire logic cpu_i_bit,
    input wire logic cpu_halted,
    input wire logic cpu_int_ack,
    input wire logic cpu_int_req,
    input wire logic [15:0] cpu_vector,
    input wire logic wake_from_halt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_trap;
        cpu_trap && !cpu_int_ack;
    endsequence
    a_ram_range:
    assert property (cpu_region.ram == (cpu_addr < RAM_BYTES && cpu_addr > 16'h003F))
        else $error("ram decode wrong");
    a_reg_page:
    assert property (cpu_region.reg_page == (cpu_addr <= 16'h003F))
        else $error("register page decode wrong");
    a_stack_window:
    assert property (cpu_region.stack == (cpu_addr inside {[16'h0100:16'h017F]}))
        else $error("stack decode wrong");
    a_vector_slots:
    assert property (cpu_region.vector == (cpu_addr >= 16'hFFEE))
        else $error("vector decode wrong");
    a_rsvd_vec:
    assert property (cpu_addr inside {[16'hFFE0:16'hFFED]} |-> cpu_region.reserved)
        else $error("reserved slot not flagged");
    a_trap_taken:
    assert property (s_trap |=> cpu_int_req && cpu_vector >= 16'hFFFC)
        else $error("trap not offered");
    a_mask_blocks:
    assert property (cpu_int_req && cpu_vector < 16'hFFFC |-> !$past(cpu_i_bit))
        else $error("masked source offered");
    a_vector_even:
    assert property (cpu_int_req |-> !cpu_vector[0] && cpu_vector >= 16'hFFEE)
        else $error("vector outside table");
    a_wake_halted:
    assert property (wake_from_halt |-> $past(cpu_halted))
        else $error("wake without halt");
    a_err_access:
    assert property (pslverr |-> psel && penable)
        else $error("error outside access");
endmodule : mvd_top_props

bind mvd_top mvd_top_props #(.RAM_BYTES(RAM_BYTES), .PROG_BYTES(PROG_BYTES)) i_mvd_top_props (
    .pclk, .presetn, .psel, .penable, .pslverr, .cpu_addr, .cpu_region, .cpu_trap,
    .cpu_i_bit, .cpu_halted, .cpu_int_ack, .cpu_int_req, .cpu_vector, .wake_from_halt);

//--- tb/mvd_top_tb.sv
// Bench for mvd_top: APB tasks, event pulses, decode sweep.
// Assumes the CPU model acks vectors; one clock pclk.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module mvd_top_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] cpu_addr, cpu_vector, taken_vector;
    logic [7:0] ev, ext, pa_o, pa_d, pb_o, pb_d;
    logic [3:0] ack_dly;
    logic cpu_mem_valid, cpu_i_bit, cpu_halted, cpu_int_ack, cpu_int_req, wake, irq, taken;
    mvd_pkg::mvd_region_t cpu_region;
    int bad_count = 0;
    int tests_run = 0;
    logic [15:0] dec_a [15] = '{16'h0000, 16'h003F, 16'h0040, 16'h0100, 16'h017F, 16'h0180,
        16'h03FF, 16'h0400, 16'h7FFF, 16'h8000, 16'hFFDF, 16'hFFE0, 16'hFFED, 16'hFFEE, 16'hFFFF};
    logic [5:0] dec_e [15] = '{6'h10, 6'h10, 6'h20, 6'h28, 6'h28, 6'h20, 6'h20, 6'h01, 6'h01,
        6'h04, 6'h04, 6'h01, 6'h01, 6'h02, 6'h02};

    mvd_top i_mvd_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .cpu_addr, .cpu_mem_valid, .cpu_region,
        .external_interrupt_lines(ext), .usb_irq(ev[0]), .async_serial_interface_irq(ev[1]),
        .two_wire_irq(ev[2]), .timer_irq(ev[3]), .usb_end_suspend(ev[5]),
        .flash_prog_start(ev[6]), .cpu_trap(ev[7]), .cpu_i_bit, .cpu_halted, .cpu_int_ack,
        .cpu_int_req, .cpu_vector, .wake_from_halt(wake), .irq, .port_a_output_value(pa_o),
        .port_a_direction(pa_d), .port_b_output_value(pb_o), .port_b_direction(pb_d));
    mvd_cpu_model i_mvd_cpu_model (.pclk, .presetn, .cpu_int_req, .cpu_vector, .ack_dly,
        .cpu_int_ack, .taken, .taken_vector);

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic end_sim;
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                bad_count++;
                end_sim();
            end
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wait_taken(input logic [15:0] v);
        int n;
        n = 0;
        while (taken !== 1'b1) begin
            n++;
            if (n > 40) begin
                bad_count++;
                end_sim();
            end
            @(posedge pclk);
        end
        `CHK(taken_vector, v)
        @(posedge pclk);
    endtask : wait_taken

    task automatic pulse(input logic [7:0] m);
        ev <= m;
        ext <= {8{m[4]}};
        @(posedge pclk);
        ev <= 8'h00;
        ext <= 8'h00;
    endtask : pulse

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, cpu_mem_valid, cpu_i_bit} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        cpu_addr = 16'h0000;
        ev = 8'h00;
        ext = 8'h00;
        cpu_halted = 1'b1;
        ack_dly = 4'h4;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK(wake, 1'b1)
        wait_taken(16'hFFFE);
        cpu_halted <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            apb(12'(4 * i), 1'b0, 32'h0);
            `CHK(rd, 32'h0)
            apb(12'(4 * i), 1'b1, 32'hFFFFFF00 | 32'(8'hA5 ^ 8'(i)));
            apb(12'(4 * i), 1'b0, 32'h0);
            `CHK(rd, 32'(8'hA5 ^ 8'(i)))
        end
        `CHK({pa_o, pa_d, pb_o, pb_d}, 32'hA5A4A7A6)
        apb(12'h020, 1'b0, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(12'h001, 1'b1, 32'h0);
        `CHK({err, pa_o}, {1'b1, 8'hA5})
        foreach (dec_a[i]) begin
            cpu_addr <= dec_a[i];
            @(posedge pclk);
            `CHK(cpu_region, dec_e[i])
        end
        apb(12'h018, 1'b1, 32'h7F);
        for (int k = 0; k < 8; k++) begin
            ack_dly <= 4'(k % 3);
            pulse(8'(1 << k));
            wait_taken(16'hFFEE + 16'(2 * k));
        end
        // Two at once: the higher slot goes first
        pulse(8'h48);
        wait_taken(16'hFFFA);
        wait_taken(16'hFFF4);
        cpu_i_bit <= 1'b1;
        pulse(8'h08);
        repeat (4) @(posedge pclk);
        `CHK(cpu_int_req, 1'b0)
        pulse(8'h80);
        wait_taken(16'hFFFC);
        cpu_i_bit <= 1'b0;
        wait_taken(16'hFFF4);
        cpu_i_bit <= 1'b1;
        cpu_halted <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            pulse(8'(1 << k));
            if (k == 7) wait_taken(16'hFFFC);
            repeat (2) @(posedge pclk);
            `CHK(wake, 1'(k inside {4, 5, 6}))
            apb(12'h014, 1'b1, 32'hFFFF);
        end
        cpu_halted <= 1'b0;
        apb(12'h018, 1'b1, 32'h0);
        pulse(8'h08);
        apb(12'h010, 1'b0, 32'h0);
        `CHK({irq, rd}, {1'b0, 32'h08})
        apb(12'h018, 1'b1, 32'h08);
        @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(12'h014, 1'b1, 32'h08);
        apb(12'h010, 1'b0, 32'h0);
        `CHK({irq, rd}, {1'b0, 32'h0})
        cpu_addr <= 16'hFFE2;
        cpu_mem_valid <= 1'b1;
        @(posedge pclk);
        cpu_mem_valid <= 1'b0;
        apb(12'h01C, 1'b0, 32'h0);
        `CHK(rd, 32'h0000FFE2)
        apb(12'h010, 1'b0, 32'h0);
        `CHK(rd, 32'h80)
        end_sim();
    end
endmodule : mvd_top_tb
